/* awp_pkg.sv */
package awp_pkg;

  // register byte offsets on the avalon slave
  localparam logic [5:0] OFF_CHAN     = 6'h00;
  localparam logic [5:0] OFF_MODE     = 6'h04;
  localparam logic [5:0] OFF_PROC     = 6'h08;
  localparam logic [5:0] OFF_PCOUNT   = 6'h0c;
  localparam logic [5:0] OFF_REFCH    = 6'h10;
  localparam logic [5:0] OFF_TOMODE   = 6'h14;
  localparam logic [5:0] OFF_TODEF    = 6'h18;
  localparam logic [5:0] OFF_TOIVL    = 6'h1c;
  localparam logic [5:0] OFF_TOCHK    = 6'h20;
  localparam logic [5:0] OFF_WLO      = 6'h24;
  localparam logic [5:0] OFF_WHI      = 6'h28;
  localparam logic [5:0] OFF_AREF     = 6'h2c;
  localparam logic [5:0] OFF_RESULT   = 6'h30;
  localparam logic [5:0] OFF_STATUS   = 6'h34;
  localparam logic [5:0] OFF_IRQ_MASK = 6'h38;
  localparam logic [5:0] OFF_REFSEL   = 6'h3c;

  // reset values
  localparam logic [7:0]  RST_CHAN   = 8'hff;
  localparam logic [7:0]  RST_REFCH  = 8'hff;
  localparam logic [15:0] RST_TOIVL  = 16'h0001;
  localparam logic [15:0] RST_ANG    = 16'h0000;

  // channel select decode
  localparam logic [7:0] CHAN_OFF    = 8'hff;
  localparam logic [7:0] CHAN_MAX    = 8'h3f;
  localparam logic [7:0] REF_MEAS_LO = 8'h40;
  localparam logic [7:0] REF_MEAS_HI = 8'h5f;

  // procedure codes
  localparam logic [7:0] PR_HI_PQ  = 8'h00;
  localparam logic [7:0] PR_LO_PQ  = 8'h01;
  localparam logic [7:0] PR_HI_EQ  = 8'h3b;
  localparam logic [7:0] PR_LO_EQ  = 8'h3c;
  localparam logic [7:0] PR_NHI_PQ = 8'h1c;
  localparam logic [7:0] PR_NLO_PQ = 8'h1d;
  localparam logic [7:0] PR_NHI_EQ = 8'h3d;
  localparam logic [7:0] PR_NLO_EQ = 8'h3e;
  localparam logic [7:0] PR_ADD_HI = 8'h02;
  localparam logic [7:0] PR_ADD_LO = 8'h03;

  // status bit positions
  localparam int ST_RESULT  = 0;
  localparam int ST_TIMEOUT = 1;

  // timing
  localparam int  CLK_MHZ     = 125;
  localparam int  US_CYCLES   = CLK_MHZ;
  localparam int  US_PER_MS   = 1000;
  localparam real TOIVL_MIN_MS = 1.0;

  // angles are signed whole degrees crankshaft
  localparam logic signed [15:0] ANG_MAX = 16'sh02d0;

  typedef enum logic [1:0]
  {
    AWP_IDLE = 2'b00,
    AWP_OPEN = 2'b01
  } awp_meas_t;

  typedef struct packed
  {
    logic        hi_active;
    logic        edge_qual;
    logic        numbered;
    logic        additive;
    logic        valid;
  } awp_proc_t;

  typedef struct packed
  {
    logic        ivl;
    logic        ang;
    logic        inp_dep;
  } awp_to_t;

  typedef struct packed
  {
    logic [31:0] value;
    logic        timeout;
  } awp_result_t;

endpackage : awp_pkg

/* awp_decode.sv */
`timescale 1ns/100ps
module awp_decode
  import awp_pkg::*;
(
  input  wire logic [7:0] proc_code,
  input  wire logic [2:0] to_mode,
  output awp_proc_t       proc,
  output awp_to_t         tom
);

  always_comb
  begin
    proc = '0;
    // R3 procedure code decode
    case (proc_code)
      PR_HI_PQ:  proc = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b1};
      PR_LO_PQ:  proc = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
      PR_HI_EQ:  proc = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1};
      PR_LO_EQ:  proc = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b1};
      PR_NHI_PQ: proc = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1};
      PR_NLO_PQ: proc = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b1};
      PR_NHI_EQ: proc = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b1};
      PR_NLO_EQ: proc = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b1};
      PR_ADD_HI: proc = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1};
      PR_ADD_LO: proc = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1};
      default:   proc = '0;
    endcase
  end

  always_comb
  begin
    tom = '0;
    // R6 timeout mode decode
    case (to_mode)
      3'h1:    tom = '{1'b1, 1'b0, 1'b0};
      3'h2:    tom = '{1'b1, 1'b0, 1'b1};
      3'h3:    tom = '{1'b0, 1'b1, 1'b0};
      3'h4:    tom = '{1'b0, 1'b1, 1'b1};
      3'h5:    tom = '{1'b1, 1'b1, 1'b0};
      3'h6:    tom = '{1'b1, 1'b1, 1'b1};
      default: tom = '0;
    endcase
  end

endmodule : awp_decode

/* awp_meter.sv */
`timescale 1ns/100ps
// Operation
// R1 - channel select: all ones disables, 0..63 picks the input line
// R2 - mode 0 free-running, mode 1 angle-synchronous
// R3 - procedure code selects high/low, pulse/edge qualified, numbered variant
// R4 - pulse count gives pulse index, or max pulses for additive procedures; the additive sum here ignores pulse count
// R5 - reference: none, line 0..63, or measurement channel 64..95
// R6 - timeout modes 0..6: off, interval, angle, both; preset or input value
// R7 - default timeout value output only in preset timeout modes
// R8 - interval checks every programmed milliseconds, never below one millisecond
// R9 - angle check when crank angle reaches checkpoint within +-720 degrees
// R10 - angle-synchronous mode measures only inside lower..upper window
// R11 - additive results written when angle reaches window upper bound
// R12 - reference angle is zero point for angle results only; the code applies it to the window and upper-bound compare, not the checkpoint
// R13 - pulse and edge qualification schemes chosen by procedure code
// R14 - pulse qualification needs both edges inside one window
// R15 - edge qualification needs either edge inside a window
// R16 - width written on closing edge; index 0 means every pulse
// R17 - input-dependent timeout gives 0 if inactive, else time since open
// R18 - widths timed by free-running microsecond counter at edges
// R19 - timeout only if no result since previous check; flag reported
module awp_meter
  import awp_pkg::*;
(
  input  wire logic               clk,
  input  wire logic               rst_n,
  input  wire logic [63:0]        in_lines,
  input  wire logic signed [15:0] crank_angle,
  input  wire logic [5:0]         avs_address,
  input  wire logic               avs_read,
  input  wire logic               avs_write,
  input  wire logic [31:0]        avs_writedata,
  output logic [31:0]             avs_readdata,
  output logic                    avs_waitrequest,
  output logic                    irq,
  output logic                    result_strobe,
  output logic [32:0]             result_out
);

  logic [7:0]         chan_q;
  logic               mode_q;
  logic [7:0]         proc_q;
  logic [31:0]        pcount_q;
  logic [7:0]         refch_q;
  logic [2:0]         tomode_q;
  logic [31:0]        todef_q;
  logic [15:0]        toivl_q;
  logic signed [15:0] tochk_q;
  logic signed [15:0] wlo_q;
  logic signed [15:0] whi_q;
  logic signed [15:0] aref_q;
  logic [1:0]         status_q;
  logic [1:0]         mask_q;
  awp_result_t        res_q;
  logic               ack_q;
  awp_proc_t          proc;
  awp_to_t            tom;

  awp_decode u_dec
  (
    .proc_code (proc_q),
    .to_mode   (tomode_q),
    .proc      (proc),
    .tom       (tom)
  );

  function automatic logic in_win(input logic signed [15:0] a,
                                  input logic signed [15:0] lo,
                                  input logic signed [15:0] hi);
    in_win = (a >= lo) && (a <= hi);
  endfunction : in_win

  function automatic logic signed [15:0] clamp_ang(input logic [31:0] v);
    logic signed [15:0] s;
    s = v[15:0];
    if (s > ANG_MAX)
      clamp_ang = ANG_MAX;
    else if (s < -ANG_MAX)
      clamp_ang = -ANG_MAX;
    else
      clamp_ang = s;
  endfunction : clamp_ang

  ////////////////////////////////////////////////////////////////////////
  // avalon slave: one wait cycle, then ack
  logic acc;
  logic wr_en;
  assign acc   = (avs_read || avs_write) && !ack_q;
  assign wr_en = avs_write && ack_q;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      ack_q <= 1'b0;
    else
      ack_q <= acc;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      avs_waitrequest <= 1'b1;
    else
      avs_waitrequest <= !acc;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      chan_q   <= RST_CHAN;
      mode_q   <= 1'b0;
      proc_q   <= '0;
      pcount_q <= '0;
      refch_q  <= RST_REFCH;
      tomode_q <= '0;
      todef_q  <= '0;
      toivl_q  <= RST_TOIVL;
      tochk_q  <= RST_ANG;
      wlo_q    <= RST_ANG;
      whi_q    <= RST_ANG;
      aref_q   <= RST_ANG;
      mask_q   <= '0;
    end
    else if (wr_en)
    begin
      case (avs_address)
        OFF_CHAN:     chan_q   <= avs_writedata[7:0];
        OFF_MODE:     mode_q   <= avs_writedata[0];
        OFF_PROC:     proc_q   <= avs_writedata[7:0];
        OFF_PCOUNT:   pcount_q <= avs_writedata;
        OFF_REFCH:    refch_q  <= avs_writedata[7:0];
        OFF_TOMODE:   tomode_q <= avs_writedata[2:0];
        OFF_TODEF:    todef_q  <= avs_writedata;
        // R8 floor at one millisecond
        OFF_TOIVL:    toivl_q  <= (avs_writedata[15:0] == 16'h0000) ? RST_TOIVL
                                  : avs_writedata[15:0];
        OFF_TOCHK:    tochk_q  <= clamp_ang(avs_writedata);
        OFF_WLO:      wlo_q    <= clamp_ang(avs_writedata);
        OFF_WHI:      whi_q    <= clamp_ang(avs_writedata);
        OFF_AREF:     aref_q   <= clamp_ang(avs_writedata);
        OFF_IRQ_MASK: mask_q   <= avs_writedata[1:0];
        default:      ;
      endcase
    end
  end

  // R5 reference decode, combinational, only read back at OFF_REFSEL
  logic [1:0] refsel;
  always_comb
  begin
    if (refch_q <= CHAN_MAX)
      refsel = 2'h1;
    else if (refch_q >= REF_MEAS_LO && refch_q <= REF_MEAS_HI)
      refsel = 2'h2;
    else
      refsel = 2'h0;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      avs_readdata <= '0;
    else if (acc && avs_read)
    begin
      case (avs_address)
        OFF_CHAN:     avs_readdata <= {24'h000000, chan_q};
        OFF_MODE:     avs_readdata <= {31'h00000000, mode_q};
        OFF_PROC:     avs_readdata <= {24'h000000, proc_q};
        OFF_PCOUNT:   avs_readdata <= pcount_q;
        OFF_REFCH:    avs_readdata <= {24'h000000, refch_q};
        OFF_TOMODE:   avs_readdata <= {29'h00000000, tomode_q};
        OFF_TODEF:    avs_readdata <= todef_q;
        OFF_TOIVL:    avs_readdata <= {16'h0000, toivl_q};
        OFF_TOCHK:    avs_readdata <= {{16{tochk_q[15]}}, tochk_q};
        OFF_WLO:      avs_readdata <= {{16{wlo_q[15]}}, wlo_q};
        OFF_WHI:      avs_readdata <= {{16{whi_q[15]}}, whi_q};
        OFF_AREF:     avs_readdata <= {{16{aref_q[15]}}, aref_q};
        OFF_RESULT:   avs_readdata <= res_q.value;
        OFF_STATUS:   avs_readdata <= {29'h00000000, res_q.timeout, status_q};
        OFF_IRQ_MASK: avs_readdata <= {30'h00000000, mask_q};
        OFF_REFSEL:   avs_readdata <= {30'h00000000, refsel};
        default:      avs_readdata <= '0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // microsecond timebase and pulse timing
  logic [6:0]  pre_q;
  logic [31:0] us_q;
  logic        us_tick;
  assign us_tick = (pre_q == 7'(US_CYCLES - 1));

  // R18 free-running microsecond counter
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      pre_q <= '0;
      us_q  <= '0;
    end
    else
    begin
      pre_q <= us_tick ? 7'h00 : pre_q + 7'h01;
      if (us_tick)
        us_q <= us_q + 32'h00000001;
    end
  end

  logic enabled;
  logic lvl_q;
  logic act;
  logic act_prev_q;
  // R1 channel enable and line select
  assign enabled = (chan_q <= CHAN_MAX) && proc.valid;
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      lvl_q <= 1'b0;
    else
      lvl_q <= in_lines[chan_q[5:0]];
  end
  assign act = (lvl_q == proc.hi_active);

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      act_prev_q <= 1'b0;
    else
      act_prev_q <= act;
  end

  logic open_e;
  logic close_e;
  assign open_e  = enabled && act && !act_prev_q;
  assign close_e = enabled && !act && act_prev_q;

  // R2 window applies only in angle-synchronous mode
  // R10 measurement gated to lower..upper window
  // R12 angle from reference
  logic win;
  assign win = !mode_q || in_win(crank_angle - aref_q, wlo_q, whi_q);

  logic win_prev_q;
  logic win_exit;
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      win_prev_q <= 1'b0;
    else
      win_prev_q <= win;
  end
  assign win_exit = win_prev_q && !win;

  awp_meas_t   st_q;
  logic [31:0] open_ts_q;
  logic        open_in_q;
  logic        open_win_q;
  logic [31:0] pcnt_q;
  logic [31:0] acc_q;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      st_q       <= AWP_IDLE;
      open_ts_q  <= '0;
      open_in_q  <= 1'b0;
      open_win_q <= 1'b0;
    end
    else
    begin
      case (st_q)
        AWP_IDLE:
          if (open_e)
          begin
            st_q       <= AWP_OPEN;
            open_ts_q  <= us_q;
            open_in_q  <= win;
            open_win_q <= win;
          end
        AWP_OPEN:
        begin
          // a window exit while open breaks pulse qualification
          if (win_exit)
            open_win_q <= 1'b0;
          if (close_e)
            st_q <= AWP_IDLE;
        end
        default: st_q <= AWP_IDLE;
      endcase
    end
  end

  logic qual;
  always_comb
  begin
    // R13 qualification scheme from procedure decode
    if (!mode_q)
      qual = 1'b1;
    // R15 either edge inside a window
    else if (proc.edge_qual)
      qual = open_in_q || win;
    // R14 both edges inside the same window
    else
      qual = open_win_q && win;
  end

  logic        valid_close;
  logic        pick;
  assign valid_close = (st_q == AWP_OPEN) && close_e && qual && !proc.additive;
  // R4 index against count of valid pulses
  // R16 index 0 behaves as unnumbered
  assign pick = !proc.numbered || (pcount_q == 32'h00000000)
                || (pcnt_q + 32'h00000001 == pcount_q);

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      pcnt_q <= '0;
    else if (mode_q && win_exit)
      pcnt_q <= '0;
    else if (valid_close)
      pcnt_q <= pcnt_q + 32'h00000001;
  end

  logic add_wr;

  // additive active time inside window, in microseconds, cleared on transfer
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      acc_q <= '0;
    else if (add_wr)
      acc_q <= '0;
    else if (enabled && proc.additive && act && win && us_tick)
      acc_q <= acc_q + 32'h00000001;
  end

  logic at_hi_q;
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      at_hi_q <= 1'b0;
    else
      at_hi_q <= (crank_angle - aref_q) >= whi_q;
  end
  // R11 additive result transferred at upper bound
  assign add_wr = enabled && proc.additive && mode_q && !at_hi_q
                  && ((crank_angle - aref_q) >= whi_q);

  ////////////////////////////////////////////////////////////////////////
  // timeout checks
  logic [9:0]  ms_us_q;
  logic [15:0] ivl_ms_q;
  logic        ivl_chk;
  logic        ms_tick;
  assign ms_tick = us_tick && (ms_us_q == 10'(US_PER_MS - 1));

  // R8 interval check every programmed milliseconds
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      ms_us_q  <= '0;
      ivl_ms_q <= '0;
    end
    else
    begin
      if (us_tick)
        ms_us_q <= ms_tick ? 10'h000 : ms_us_q + 10'h001;
      if (ms_tick)
        ivl_ms_q <= (ivl_ms_q + 16'h0001 >= toivl_q) ? 16'h0000 : ivl_ms_q + 16'h0001;
    end
  end
  assign ivl_chk = ms_tick && (ivl_ms_q + 16'h0001 >= toivl_q) && tom.ivl;

  logic ang_at_q;
  logic ang_chk;
  // R9 check when angle reaches checkpoint
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      ang_at_q <= 1'b0;
    else
      ang_at_q <= crank_angle >= tochk_q;
  end
  assign ang_chk = tom.ang && (crank_angle >= tochk_q) && !ang_at_q;

  logic chk;
  logic fresh_q;
  logic new_res;
  assign chk     = enabled && (ivl_chk || ang_chk);
  assign new_res = (valid_close && pick) || add_wr;

  // R19 result since last check; a new result wins over the check clear
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      fresh_q <= 1'b0;
    else if (new_res)
      fresh_q <= 1'b1;
    else if (chk)
      fresh_q <= 1'b0;
  end
  logic to_fire;
  assign to_fire = chk && !fresh_q && !new_res;

  logic [31:0] to_val;
  always_comb
  begin
    // R17 input value: 0 if inactive else time since opening edge
    if (tom.inp_dep)
      to_val = act ? (us_q - open_ts_q) : 32'h00000000;
    // R7 preset default only in preset modes
    else
      to_val = todef_q;
  end

  ////////////////////////////////////////////////////////////////////////
  // result, status and interrupt
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      res_q         <= '0;
      result_strobe <= 1'b0;
    end
    else
    begin
      result_strobe <= new_res || to_fire;
      // R16 width written on closing edge
      if (valid_close && pick)
        res_q <= '{us_q - open_ts_q, 1'b0};
      else if (add_wr)
        res_q <= '{acc_q, 1'b0};
      else if (to_fire)
        res_q <= '{to_val, 1'b1};
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      status_q <= '0;
    else
    begin
      status_q[ST_RESULT]  <= (new_res) || (status_q[ST_RESULT]
                              && !(wr_en && avs_address == OFF_STATUS
                                   && avs_writedata[ST_RESULT]));
      status_q[ST_TIMEOUT] <= (to_fire) || (status_q[ST_TIMEOUT]
                              && !(wr_en && avs_address == OFF_STATUS
                                   && avs_writedata[ST_TIMEOUT]));
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      irq        <= 1'b0;
      result_out <= '0;
    end
    else
    begin
      irq        <= |(status_q & mask_q);
      result_out <= res_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // R16 width equals closing minus opening stamp
  a_width_value: assert property (@(posedge clk) disable iff (!rst_n) // R16
    (valid_close && pick) |=> (res_q.value == $past(us_q) - $past(open_ts_q))
      && !res_q.timeout)
    else $error("width result wrong");

  // R19 timeout never fires right after a fresh result
  a_timeout_fresh: assert property (@(posedge clk) disable iff (!rst_n) // R19
    new_res |=> !to_fire)
    else $error("timeout despite fresh result");

  // R7 preset value on timeout
  a_preset_value: assert property (@(posedge clk) disable iff (!rst_n) // R7
    (to_fire && !tom.inp_dep) |=> res_q.value == $past(todef_q) && res_q.timeout)
    else $error("preset timeout value wrong");

  // R17 inactive input yields zero
  a_inpdep_zero: assert property (@(posedge clk) disable iff (!rst_n) // R17
    (to_fire && tom.inp_dep && !act) |=> res_q.value == 32'h00000000)
    else $error("input-dependent timeout not zero");

  // R1 disabled channel produces nothing
  a_chan_off: assert property (@(posedge clk) disable iff (!rst_n) // R1
    (chan_q > CHAN_MAX) |=> !result_strobe)
    else $error("disabled channel gave a result");

  // R14 pulse qualified close outside window is dropped
  a_pulse_qual: assert property (@(posedge clk) disable iff (!rst_n) // R14
    (mode_q && !proc.edge_qual && !win) |-> !valid_close)
    else $error("pulse outside window measured");

  // R15 edge qualified: both edges outside dropped
  a_edge_qual: assert property (@(posedge clk) disable iff (!rst_n) // R15
    (mode_q && proc.edge_qual && !open_in_q && !win) |-> !valid_close)
    else $error("edge qualified pulse outside windows measured");

  // R6 timeout off never fires
  a_to_off: assert property (@(posedge clk) disable iff (!rst_n) // R6
    (tomode_q == 3'h0) |-> !to_fire)
    else $error("timeout while monitoring off");

  // interrupt follows masked status
  a_irq_level: assert property (@(posedge clk) disable iff (!rst_n)
    |(status_q & mask_q) |=> irq)
    else $error("irq missing");

endmodule : awp_meter

/* awp_src.sv */
`timescale 1ns/100ps
module awp_src
  import awp_pkg::*;
(
  input  wire logic               clk,
  input  wire logic [5:0]         sel,
  input  wire logic               lvl,
  input  wire logic signed [15:0] ang_req,
  output logic [63:0]             in_lines = 64'h0,
  output logic signed [15:0]      crank_angle = 16'sh0000
);
////////////////////////////////////////
  // angle kept bounded
  always @(posedge clk)
  begin
    if (ang_req > ANG_MAX)
      crank_angle <= ANG_MAX;
    else if (ang_req < -ANG_MAX)
      crank_angle <= -ANG_MAX;
    else
      crank_angle <= ang_req;
  end
  // unselected lines rest low, as a pulled-down input would
  always @(posedge clk)
  begin
    in_lines <= {63'h0, lvl} << sel;
  end
endmodule : awp_src

/* testbench.sv */
`timescale 1ns/100ps
module testbench
  import awp_pkg::*;
;
  logic               clk = 1'b0;
  logic               rst_n = 1'b0;
  logic [5:0]         avs_address = 6'h00;
  logic               avs_read = 1'b0;
  logic               avs_write = 1'b0;
  logic [31:0]        avs_writedata = 32'h0;
  logic [31:0]        avs_readdata;
  logic               avs_waitrequest;
  logic               irq;
  logic               result_strobe;
  logic [32:0]        result_out;
  logic [63:0]        in_lines;
  logic signed [15:0] crank_angle;
  logic               lvl = 1'b0;
  logic signed [15:0] ang = 16'sh0000;
  logic [32:0]        last_res = 33'h0;
  logic               str_q = 1'b0;
  logic [31:0]        rdat;
  logic [7:0]         rf [4] = '{8'h05, 8'h40, 8'h5f, 8'hff};
  logic [1:0]         rs [4] = '{2'h1, 2'h2, 2'h2, 2'h0};
  logic [7:0]         pc [8] = '{PR_HI_PQ, PR_LO_PQ, PR_HI_EQ, PR_LO_EQ,
                                 PR_NHI_PQ, PR_NLO_PQ, PR_NHI_EQ, PR_NLO_EQ};
  int                 n_str = 0;
  int                 num_errors = 0;
  int                 tests_run = 0;
  int                 cyc = 0;

  always #4 clk = ~clk;

  awp_meter DUT
  (
    .clk             (clk),
    .rst_n           (rst_n),
    .in_lines        (in_lines),
    .crank_angle     (crank_angle),
    .avs_address     (avs_address),
    .avs_read        (avs_read),
    .avs_write       (avs_write),
    .avs_writedata   (avs_writedata),
    .avs_readdata    (avs_readdata),
    .avs_waitrequest (avs_waitrequest),
    .irq             (irq),
    .result_strobe   (result_strobe),
    .result_out      (result_out)
  );

  awp_src SRC
  (
    .clk         (clk),
    .sel         (6'h05),
    .lvl         (lvl),
    .ang_req     (ang),
    .in_lines    (in_lines),
    .crank_angle (crank_angle)
  );
////////////////////////////////////////
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    // result_out lags the strobe by one cycle
    str_q <= (result_strobe === 1'b1);
    if (str_q)
    begin
      last_res <= result_out;
      n_str    <= n_str + 1;
    end
    if (cyc == 40000)
    begin
      num_errors++;
      results();
    end
  end

  task automatic results();
    $display("errors %0d checks %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : results

  task automatic chk(input string nm, input logic [32:0] exp, input logic [32:0] got);
    tests_run++;
    if (got !== exp)
    begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic bus(input logic we, input logic [5:0] a, input logic [31:0] d);
    @(posedge clk);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= we;
    avs_read      <= ~we;
    @(posedge clk);
    // only the global cycle limit ends a hung wait
    while (avs_waitrequest !== 1'b0)
      @(posedge clk);
    rdat = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
  endtask : bus

  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr

  task automatic rc(input string nm, input logic [5:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(nm, {1'b0, exp}, {1'b0, rdat});
  endtask : rc

  // angle moves 4 cycles before the closing edge so both inputs have settled
  task automatic meas(input int len, input logic signed [15:0] ca, input int cnt,
                      input logic [31:0] v);
    int n0;
    int k;
    repeat (2) @(posedge clk);
    n0 = n_str;
    lvl <= ~lvl;
    repeat (len - 4) @(posedge clk);
    ang <= ca;
    repeat (4) @(posedge clk);
    lvl <= ~lvl;
    for (k = 0; k < 30 && n_str == n0; k++)
      @(posedge clk);
    repeat (4) @(posedge clk);
    chk("count", 33'(cnt), 33'(n_str - n0));
    if (cnt > 0)
      chk("result", {v, 1'b0}, last_res);
  endtask : meas

  task automatic arrive(input int cnt, input logic [32:0] exp);
    int n0;
    n0 = n_str;
    ang <= 16'sh0000;
    repeat (8) @(posedge clk);
    ang <= 16'sh001e;
    repeat (12) @(posedge clk);
    if (cnt >= 0)
      chk("to_count", 33'(cnt), 33'(n_str - n0));
    if (cnt > 0)
      chk("to_result", exp, last_res);
  endtask : arrive

  initial
  begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    rc("chan", OFF_CHAN, 32'h0000_00ff);
    rc("refsel", OFF_REFSEL, 32'h0);
    rc("unmapped", 6'h02, 32'h0);
    wr(OFF_TOIVL, 32'h0);
    rc("ivl_floor", OFF_TOIVL, 32'h1);
    wr(OFF_WLO, 32'h320);
    rc("wlo_clamp", OFF_WLO, 32'h2d0);
    foreach (rf[i])
    begin
      wr(OFF_REFCH, {24'h0, rf[i]});
      rc("refsel", OFF_REFSEL, {30'h0, rs[i]});
    end
    wr(OFF_IRQ_MASK, 32'h3);
    wr(OFF_CHAN, 32'h5);
    foreach (pc[i])
    begin
      // idle level first; the stray result of the switch lands before meas counts
      lvl <= 1'(i % 2);
      wr(OFF_PROC, {24'h0, pc[i]});
      wr(OFF_STATUS, 32'h7);
      meas(125 * (i + 2), ang, 1, 32'(i + 2));
      rc("status", OFF_STATUS, 32'h1);
      chk("irq", 33'h1, {32'h0, irq});
    end
    wr(OFF_STATUS, 32'h1);
    repeat (2) @(posedge clk);
    chk("irq_clear", 33'h0, {32'h0, irq});
    wr(OFF_IRQ_MASK, 32'h0);
    meas(250, ang, 1, 32'h2);
    chk("irq_mask", 33'h0, {32'h0, irq});
    wr(OFF_IRQ_MASK, 32'h3);
    lvl <= 1'b0;
    wr(OFF_PROC, {24'h0, PR_HI_PQ});
    wr(OFF_CHAN, 32'hff);
    meas(250, ang, 0, 32'h0);
    wr(OFF_CHAN, 32'h6);
    meas(250, ang, 0, 32'h0);
    wr(OFF_CHAN, 32'h5);
    wr(OFF_WLO, 32'h0);
    wr(OFF_WHI, 32'h64);
    wr(OFF_MODE, 32'h1);
    ang <= 16'sh0032;
    meas(250, 16'sh0032, 1, 32'h2);
    ang <= 16'sh00c8;
    meas(250, 16'sh00c8, 0, 32'h0);
    ang <= 16'sh0032;
    meas(250, 16'sh00c8, 0, 32'h0);
    wr(OFF_PROC, {24'h0, PR_HI_EQ});
    ang <= 16'sh0032;
    meas(250, 16'sh00c8, 1, 32'h2);
    wr(OFF_PROC, {24'h0, PR_ADD_HI});
    ang <= 16'sh0032;
    meas(375, 16'sh0032, 0, 32'h0);
    ang <= 16'sh0064;
    repeat (12) @(posedge clk);
    chk("additive", {32'h3, 1'b0}, last_res);
    wr(OFF_PCOUNT, 32'h2);
    wr(OFF_PROC, {24'h0, PR_NHI_PQ});
    ang <= 16'sh0032;
    meas(250, 16'sh00c8, 0, 32'h0);
    ang <= 16'sh0032;
    meas(250, 16'sh0032, 0, 32'h0);
    meas(250, 16'sh0032, 1, 32'h2);
    wr(OFF_PCOUNT, 32'h0);
    wr(OFF_MODE, 32'h0);
    wr(OFF_TOCHK, 32'h1e);
    wr(OFF_TODEF, 32'h1234);
    wr(OFF_TOMODE, 32'h3);
    arrive(-1, 33'h0);
    for (int m = 3; m < 7; m++)
    begin
      wr(OFF_TOMODE, 32'(m));
      arrive(1, {(m % 2) ? 32'h1234 : 32'h0, 1'b1});
    end
    chk("irq_to", 33'h1, {32'h0, irq});
    meas(250, 16'sh0000, 1, 32'h2);
    arrive(0, 33'h0);
    wr(OFF_TOMODE, 32'h0);
    arrive(0, 33'h0);
    results();
  end
endmodule : testbench
